/* File: hw/rcv_regs.sv */
/*
 * Third-rail voltage target register bank and target ramp logic, plus the
 * system power report bytes. Register access is a simple byte port fed by
 * the serial management slave; processor commands arrive as one-cycle
 * strobes from logic on the same clock. No synchronisers are needed.
 */
// Notes on behaviour
// R1: Power report is 10 bits; high byte read first snapshots the low byte.
// R2: Power code scales linearly; full code 1023 means maximum of the scale.
// R3: Host offset is two's complement, bit 7 sign, 5 mV per step.
// R4: Combined target is clamped to the 0.25 V to 2.8 V code range.
// R5: Host offset change ramps at a quarter of processor upward slew.
// R6: Offset ramps never run slower than 2.5 mV per microsecond.
// R7: Offset write forces full power state until output settles on target.
// R8: Power-state commands during an active offset are obeyed; offset stays.
// R9: Processor voltage-off command drives output to 0 V despite host offset.
// R10: Fixed-target enable is bit 0 of its register, reset disabled.
// R11: Fixed-target mode ignores processor target and power-state commands.
// R12: Fixed-target mode does not apply the host output offset.
// R13: Leaving fixed-target mode restores last processor target and state.
// R14: Entering or leaving fixed-target mode ramps at quarter upward slew.
// R15: Fixed code bit 8 from high register bit 0, bits 7:0 from low.
// R16: Fixed code zero is the off code and drives 0 V.
// R17: Non-zero fixed code sets 0.245 V plus 5 mV per step.
// R18: Host offset power-up value is loaded from nonvolatile configuration.
// R19: Reserved and read-only bits ignore writes, read zero; reads are harmless.
`timescale 1ns/1ps
`default_nettype none

module rcv_regs
    import rcv_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] nvm_offset_default,
    input wire logic cpu_target_valid,
    input wire logic [8:0] cpu_target_code,
    input wire logic [7:0] cpu_offset_code,
    input wire logic cpu_off_cmd,
    input wire logic cpu_state_valid,
    input wire logic [2:0] cpu_state_code,
    input wire logic [7:0] cpu_up_slew,
    input wire logic [9:0] system_power_code,
    input wire logic [9:0] current_report_code,
    input wire logic [7:0] temperature_code,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] rejected_status,
    output logic [8:0] vout_code,
    output logic [2:0] power_state,
    output logic ramp_busy
);

    localparam int NREG = 43;

    // Writable bits per offset; zero marks read-only or unmapped
    function automatic logic [7:0] rcv_wmask(input logic [7:0] a);
        case (a)
            RCV_ADDR_OFFSET, RCV_ADDR_FIX_LO, RCV_ADDR_CUR_RATIO,
            RCV_ADDR_FIX_MAX_LO, RCV_ADDR_OC_HYS,
            RCV_ADDR_HOT_TH, RCV_ADDR_OT_TH: rcv_wmask = RCV_MASK_FULL;
            RCV_ADDR_FIX_EN, RCV_ADDR_FIX_HI, RCV_ADDR_FULL_FORCE,
            RCV_ADDR_FIX_MAX_HI: rcv_wmask = RCV_MASK_BIT0;
            RCV_ADDR_PROT_EN: rcv_wmask = RCV_MASK_PROT_EN;
            RCV_ADDR_DROOP: rcv_wmask = RCV_MASK_DROOP;
            RCV_ADDR_MISC: rcv_wmask = RCV_MASK_MISC;
            default: rcv_wmask = 8'h00;
        endcase
    endfunction : rcv_wmask

    function automatic logic [7:0] rcv_rstval(input logic [7:0] a);
        case (a)
            RCV_ADDR_OFFSET: rcv_rstval = RCV_RST_OFFSET;
            RCV_ADDR_FIX_EN: rcv_rstval = RCV_RST_FIX_EN;
            RCV_ADDR_FIX_LO: rcv_rstval = RCV_RST_FIX_LO;
            RCV_ADDR_FIX_HI: rcv_rstval = RCV_RST_FIX_HI;
            RCV_ADDR_FULL_FORCE: rcv_rstval = RCV_RST_FULL_FORCE;
            RCV_ADDR_PROT_EN: rcv_rstval = RCV_RST_PROT_EN;
            RCV_ADDR_DROOP: rcv_rstval = RCV_RST_DROOP;
            RCV_ADDR_CUR_RATIO: rcv_rstval = RCV_RST_CUR_RATIO;
            RCV_ADDR_FIX_MAX_LO: rcv_rstval = RCV_RST_FIX_MAX_LO;
            RCV_ADDR_FIX_MAX_HI: rcv_rstval = RCV_RST_FIX_MAX_HI;
            RCV_ADDR_OC_HYS: rcv_rstval = RCV_RST_OC_HYS;
            RCV_ADDR_MISC: rcv_rstval = RCV_RST_MISC;
            RCV_ADDR_HOT_TH: rcv_rstval = RCV_RST_HOT_TH;
            RCV_ADDR_OT_TH: rcv_rstval = RCV_RST_OT_TH;
            default: rcv_rstval = 8'h00;
        endcase
    endfunction : rcv_rstval

    // Rate floor shared by both ramp speeds
    function automatic logic [11:0] rcv_floor(input logic [11:0] r);
        rcv_floor = (r < 12'(RCV_MIN_SLOW_QMV)) ? 12'(RCV_MIN_SLOW_QMV) : r;
    endfunction : rcv_floor

    logic [7:0] reg_ff [0:NREG-1];
    logic nvm_loaded_ff;
    logic [8:0] cpu_target_ff;
    logic cpu_off_ff;
    logic [2:0] cpu_state_ff;
    logic [7:0] pwr_lo_snap_ff;
    logic [7:0] cur_lo_snap_ff;
    logic offset_ramp_ff;
    logic slow_ramp_ff;
    logic [11:0] acc_ff;
    logic [8:0] vout_code_ff;
    logic [2:0] power_state_ff;
    logic ramp_busy_ff;
    logic [7:0] reg_rdata_ff;
    rcv_ramp_type ramp_state_ff;

    // Address decode
    wire logic in_range = (reg_addr >= RCV_ADDR_FIRST) && (reg_addr <= RCV_ADDR_LAST);
    wire logic [5:0] idx = 6'(reg_addr - RCV_ADDR_FIRST);
    wire logic [7:0] wmask = rcv_wmask(reg_addr);
    // Writes are dropped until the configuration load has landed
    wire logic wr_hit = reg_write && in_range && (wmask != 8'h00) && nvm_loaded_ff; // R19

    // Current settings
    wire logic [7:0] host_offset = reg_ff[6'(RCV_ADDR_OFFSET - RCV_ADDR_FIRST)];
    wire logic fixed_mode =
        reg_ff[6'(RCV_ADDR_FIX_EN - RCV_ADDR_FIRST)][RCV_FIX_EN_BIT]; // R10
    wire logic [8:0] fixed_code = {
        reg_ff[6'(RCV_ADDR_FIX_HI - RCV_ADDR_FIRST)][RCV_FIX_HI_BIT],
        reg_ff[6'(RCV_ADDR_FIX_LO - RCV_ADDR_FIRST)]}; // R15
    wire logic full_force =
        reg_ff[6'(RCV_ADDR_FULL_FORCE - RCV_ADDR_FIRST)][RCV_FULL_FORCE_BIT];

    // Write events that start a slow ramp
    wire logic offset_write = wr_hit && (reg_addr == RCV_ADDR_OFFSET);
    wire logic offset_evt = offset_write && !fixed_mode; // R12
    wire logic fix_toggle = wr_hit && (reg_addr == RCV_ADDR_FIX_EN) &&
        (reg_wdata[RCV_FIX_EN_BIT] != fixed_mode); // R14

    // Processor commands are dropped while fixed mode holds the rail
    wire logic take_target = cpu_target_valid && !fixed_mode; // R11
    wire logic take_state = cpu_state_valid && !fixed_mode; // R11
    wire logic take_off = cpu_off_cmd && !fixed_mode; // R11

    // Target sum in signed code steps; 5 mV per step on every term
    wire logic signed [10:0] host_term = fixed_mode ? 11'sd0 :
        11'(signed'(host_offset)); // R3 R12
    wire logic signed [10:0] sum = signed'({2'b00, cpu_target_ff}) +
        11'(signed'(cpu_offset_code)) + host_term;
    wire logic [8:0] clamped = (sum < signed'({2'b00, RCV_CODE_MIN})) ? RCV_CODE_MIN :
        (sum > signed'({2'b00, RCV_CODE_MAX})) ? RCV_CODE_MAX : sum[8:0]; // R4
    wire logic [8:0] normal_target = (cpu_off_ff || (cpu_target_ff == RCV_CODE_OFF)) ?
        RCV_CODE_OFF : clamped; // R9
    // Fixed code 0 is off; any other code maps straight to the output code
    wire logic [8:0] target = fixed_mode ? fixed_code : normal_target; // R13 R16 R17

    wire logic at_target = (vout_code_ff == target);

    // Quarter-millivolt per microsecond rates; slow ramp is a quarter of full unless floored
    wire logic [11:0] slow_rate = rcv_floor({4'h0, cpu_up_slew}); // R5 R6
    wire logic [11:0] full_rate = rcv_floor({2'b00, cpu_up_slew, 2'b00});
    // Flag, not state, picks the rate so a slow ramp's first cycle is slow too
    wire logic [11:0] rate = slow_ramp_ff ? slow_rate : full_rate; // R5
    wire logic [11:0] acc_sum = acc_ff + rate;
    wire logic step = (ramp_state_ff != RCV_RAMP_IDLE) && !at_target &&
        (acc_sum >= RCV_STEP_THRESH);

    // Next values
    wire logic nxt_offset_ramp = offset_evt || (offset_ramp_ff && !at_target); // R7
    wire logic nxt_slow_ramp = offset_evt || fix_toggle ||
        (slow_ramp_ff && !at_target); // R5 R14
    wire logic [11:0] nxt_acc = at_target ? 12'h000 :
        step ? (acc_sum - RCV_STEP_THRESH) : acc_sum;
    wire logic [8:0] nxt_vout = !step ? vout_code_ff :
        (vout_code_ff < target) ? (vout_code_ff + 9'h001) : (vout_code_ff - 9'h001);
    // Forced full state during the offset ramp or while full_force is set, commanded state otherwise
    wire logic [2:0] nxt_power_state = (full_force || offset_ramp_ff) ?
        RCV_STATE_FULL : cpu_state_ff; // R7 R8 R13
    wire rcv_ramp_type nxt_ramp_state = at_target ? RCV_RAMP_IDLE :
        (slow_ramp_ff ? RCV_RAMP_SLOW : RCV_RAMP_FULL);

    // Read data; reserved and unmapped bits read zero
    wire logic [7:0] rd_value =
        (reg_addr == RCV_ADDR_PWR_HI) ? {6'h00, system_power_code[9:8]} : // R1 R2
        (reg_addr == RCV_ADDR_PWR_LO) ? pwr_lo_snap_ff : // R1
        (reg_addr == RCV_ADDR_CUR_HI) ? {6'h00, current_report_code[9:8]} :
        (reg_addr == RCV_ADDR_CUR_LO) ? cur_lo_snap_ff :
        (reg_addr == RCV_ADDR_TEMP) ? temperature_code :
        (reg_addr == RCV_ADDR_VOLT_HI) ? {7'h00, vout_code_ff[8]} :
        (reg_addr == RCV_ADDR_VOLT_LO) ? vout_code_ff[7:0] :
        (reg_addr == RCV_ADDR_FAULT) ? fault_flags :
        (reg_addr == RCV_ADDR_REJECT) ? rejected_status :
        in_range ? (reg_ff[idx] & wmask) : 8'h00; // R19

    // Register file; offset power-up value arrives from configuration memory
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NREG; i++) begin
                reg_ff[i] <= rcv_rstval(8'(i) + RCV_ADDR_FIRST);
            end
            nvm_loaded_ff <= 1'b0;
        end else begin
            nvm_loaded_ff <= 1'b1;
            if (!nvm_loaded_ff) begin
                reg_ff[6'(RCV_ADDR_OFFSET - RCV_ADDR_FIRST)] <= nvm_offset_default; // R18
            end else if (wr_hit) begin
                reg_ff[idx] <= (reg_ff[idx] & ~wmask) | (reg_wdata & wmask); // R19
            end
        end
    end

    // Processor command capture
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cpu_target_ff <= RCV_CODE_OFF;
            cpu_off_ff <= 1'b0;
            cpu_state_ff <= RCV_STATE_FULL;
        end else begin
            if (take_target) begin
                cpu_target_ff <= cpu_target_code;
            end
            // A new target packet wakes the rail; off wins if both arrive
            if (take_off) begin
                cpu_off_ff <= 1'b1; // R9
            end else if (take_target) begin
                cpu_off_ff <= 1'b0;
            end
            if (take_state) begin
                cpu_state_ff <= cpu_state_code; // R8
            end
        end
    end

    // Report snapshots keep the two bytes of one sample together
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwr_lo_snap_ff <= 8'h00;
            cur_lo_snap_ff <= 8'h00;
            reg_rdata_ff <= 8'h00;
        end else begin
            if (reg_read && (reg_addr == RCV_ADDR_PWR_HI)) begin
                pwr_lo_snap_ff <= system_power_code[7:0]; // R1
            end
            if (reg_read && (reg_addr == RCV_ADDR_CUR_HI)) begin
                cur_lo_snap_ff <= current_report_code[7:0];
            end
            if (reg_read) begin
                reg_rdata_ff <= rd_value;
            end
        end
    end

    // Ramp engine
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            offset_ramp_ff <= 1'b0;
            slow_ramp_ff <= 1'b0;
            acc_ff <= 12'h000;
            vout_code_ff <= RCV_CODE_OFF;
            power_state_ff <= RCV_STATE_FULL;
            ramp_busy_ff <= 1'b0;
            ramp_state_ff <= RCV_RAMP_IDLE;
        end else begin
            offset_ramp_ff <= nxt_offset_ramp;
            slow_ramp_ff <= nxt_slow_ramp;
            acc_ff <= nxt_acc;
            vout_code_ff <= nxt_vout;
            power_state_ff <= nxt_power_state;
            ramp_busy_ff <= !at_target;
            ramp_state_ff <= nxt_ramp_state;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign vout_code = vout_code_ff;
    assign power_state = power_state_ff;
    assign ramp_busy = ramp_busy_ff;

endmodule : rcv_regs

`default_nettype wire

/* File: shared/rcv_pkg.sv */
/*
 * Constants for the third-rail target register bank: register offsets,
 * reset values, write masks, voltage code limits and ramp timing.
 * Assumes a 100 MHz system clock and 8-bit register data.
 */
`default_nettype none

package rcv_pkg;

    // Register offsets
    localparam logic [7:0] RCV_ADDR_FIRST = 8'h80;
    localparam logic [7:0] RCV_ADDR_LAST = 8'haa;
    localparam logic [7:0] RCV_ADDR_OFFSET = 8'h80;
    localparam logic [7:0] RCV_ADDR_FIX_EN = 8'h81;
    localparam logic [7:0] RCV_ADDR_FIX_LO = 8'h82;
    localparam logic [7:0] RCV_ADDR_FIX_HI = 8'h83;
    localparam logic [7:0] RCV_ADDR_FULL_FORCE = 8'h84;
    localparam logic [7:0] RCV_ADDR_PROT_EN = 8'h85;
    localparam logic [7:0] RCV_ADDR_DROOP = 8'h86;
    localparam logic [7:0] RCV_ADDR_CUR_HI = 8'h87;
    localparam logic [7:0] RCV_ADDR_CUR_LO = 8'h88;
    localparam logic [7:0] RCV_ADDR_CUR_RATIO = 8'h89;
    localparam logic [7:0] RCV_ADDR_TEMP = 8'h8a;
    localparam logic [7:0] RCV_ADDR_VOLT_HI = 8'h8b;
    localparam logic [7:0] RCV_ADDR_VOLT_LO = 8'h8c;
    localparam logic [7:0] RCV_ADDR_FAULT = 8'h8d;
    localparam logic [7:0] RCV_ADDR_REJECT = 8'h8e;
    localparam logic [7:0] RCV_ADDR_FIX_MAX_LO = 8'h9c;
    localparam logic [7:0] RCV_ADDR_FIX_MAX_HI = 8'h9d;
    localparam logic [7:0] RCV_ADDR_OC_HYS = 8'h9e;
    localparam logic [7:0] RCV_ADDR_MISC = 8'h9f;
    localparam logic [7:0] RCV_ADDR_HOT_TH = 8'ha1;
    localparam logic [7:0] RCV_ADDR_OT_TH = 8'ha2;
    localparam logic [7:0] RCV_ADDR_PWR_HI = 8'ha9;
    localparam logic [7:0] RCV_ADDR_PWR_LO = 8'haa;

    // Reset values
    localparam logic [7:0] RCV_RST_OFFSET = 8'h00;
    localparam logic [7:0] RCV_RST_FIX_EN = 8'h00;
    localparam logic [7:0] RCV_RST_FIX_LO = 8'h83;
    localparam logic [7:0] RCV_RST_FIX_HI = 8'h00;
    localparam logic [7:0] RCV_RST_FULL_FORCE = 8'h00;
    localparam logic [7:0] RCV_RST_PROT_EN = 8'h7f;
    localparam logic [7:0] RCV_RST_DROOP = 8'h0a;
    localparam logic [7:0] RCV_RST_CUR_RATIO = 8'h00;
    localparam logic [7:0] RCV_RST_FIX_MAX_LO = 8'hff;
    localparam logic [7:0] RCV_RST_FIX_MAX_HI = 8'h01;
    localparam logic [7:0] RCV_RST_OC_HYS = 8'h00;
    localparam logic [7:0] RCV_RST_MISC = 8'h00;
    localparam logic [7:0] RCV_RST_HOT_TH = 8'h8c;
    localparam logic [7:0] RCV_RST_OT_TH = 8'ha5;

    // Writable bits
    localparam logic [7:0] RCV_MASK_FULL = 8'hff;
    localparam logic [7:0] RCV_MASK_BIT0 = 8'h01;
    localparam logic [7:0] RCV_MASK_PROT_EN = 8'h7f;
    localparam logic [7:0] RCV_MASK_DROOP = 8'h9f;
    localparam logic [7:0] RCV_MASK_MISC = 8'h0f;

    // Field positions
    localparam int RCV_FIX_EN_BIT = 0;
    localparam int RCV_FIX_HI_BIT = 0;
    localparam int RCV_FULL_FORCE_BIT = 0;

    // Voltage codes: 0 is off, else 0.245 V + code x 5 mV
    localparam logic [8:0] RCV_CODE_OFF = 9'h000;
    localparam logic [8:0] RCV_CODE_MIN = 9'h001;
    localparam logic [8:0] RCV_CODE_MAX = 9'h1ff;
    localparam logic [2:0] RCV_STATE_FULL = 3'h0;

    // Ramp timing, rates in quarter-millivolts per microsecond
    localparam int RCV_CLK_PERIOD_NS = 10;
    localparam int RCV_US_NS = 1000;
    localparam int RCV_CYCLES_PER_US = RCV_US_NS / RCV_CLK_PERIOD_NS;
    localparam int RCV_STEP_QMV = 20;
    localparam int RCV_MIN_SLOW_QMV = 10;
    localparam logic [11:0] RCV_STEP_THRESH = 12'(RCV_STEP_QMV * RCV_CYCLES_PER_US);

    typedef enum logic [2:0] {
        RCV_RAMP_IDLE = 3'b001,
        RCV_RAMP_FULL = 3'b010,
        RCV_RAMP_SLOW = 3'b100
    } rcv_ramp_type;

endpackage : rcv_pkg

`default_nettype wire

/* File: tb/rcv_cpu_model.sv */
/* Processor command model: turns one-cycle bench requests into strobes.
   Kind 0 target, 1 off, 2 power state; same clock as the block. */
`timescale 1ns/1ps
`default_nettype none
module rcv_cpu_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [1:0] go_kind,
    input wire logic [8:0] go_code,
    output logic cpu_target_valid = 1'b0,
    output logic [8:0] cpu_target_code = 9'h000,
    output logic cpu_off_cmd = 1'b0,
    output logic cpu_state_valid = 1'b0,
    output logic [2:0] cpu_state_code = 3'h0
);
    wire logic tgt = go && go_kind == 2'd0;
    wire logic st = go && go_kind == 2'd2;
    always @(posedge clk_sys) begin
        cpu_target_valid <= tgt;
        cpu_off_cmd <= go && go_kind == 2'd1;
        cpu_state_valid <= st;
        // Code lines toggle outside a strobe so stale values are never trusted
        cpu_target_code <= tgt ? go_code : ~cpu_target_code;
        cpu_state_code <= st ? go_code[2:0] : ~cpu_state_code;
    end
endmodule : rcv_cpu_model
`default_nettype wire

/* File: tb/rcv_regs_bench.sv */
/* Self-checking bench for rcv_regs: byte register tasks plus processor
   commands through rcv_cpu_model; 100 MHz clock, reset held 6 cycles. */
`timescale 1ns/1ps
`default_nettype none
module rcv_regs_bench
    import rcv_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] cpu_offset_code = 8'h00;
    logic [7:0] cpu_up_slew = 8'hff;
    logic [9:0] system_power_code = 10'h2c5;
    logic [7:0] reg_rdata, rd;
    logic [8:0] vout_code, cpu_target_code, go_code = 9'h000;
    logic [2:0] power_state, cpu_state_code;
    logic ramp_busy, cpu_target_valid, cpu_off_cmd, cpu_state_valid, go = 1'b0;
    logic [1:0] go_kind = 2'd0;
    int n_mismatch = 0;
    int checked = 0;
    int waited;
    logic [7:0] t_addr[14] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
        8'h89, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha1, 8'ha2};
    logic [7:0] t_rst[14] = '{8'h05, 8'h00, 8'h83, 8'h00, 8'h00, 8'h7f, 8'h0a,
        8'h00, 8'hff, 8'h01, 8'h00, 8'h00, 8'h8c, 8'ha5};
    logic [7:0] t_msk[14] = '{8'hff, 8'h01, 8'hff, 8'h01, 8'h01, 8'h7f, 8'h9f,
        8'hff, 8'hff, 8'h01, 8'hff, 8'h0f, 8'hff, 8'hff};
    always #5 clk_sys = ~clk_sys;
    rcv_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .nvm_offset_default(8'h05), .cpu_target_valid(cpu_target_valid),
        .cpu_target_code(cpu_target_code), .cpu_offset_code(cpu_offset_code),
        .cpu_off_cmd(cpu_off_cmd), .cpu_state_valid(cpu_state_valid),
        .cpu_state_code(cpu_state_code), .cpu_up_slew(cpu_up_slew),
        .system_power_code(system_power_code), .current_report_code(10'h13a),
        .temperature_code(8'h5a), .fault_flags(8'h21), .rejected_status(8'h44),
        .vout_code(vout_code), .power_state(power_state), .ramp_busy(ramp_busy));
    rcv_cpu_model cpu_u (.clk_sys(clk_sys), .go(go), .go_kind(go_kind), .go_code(go_code),
        .cpu_target_valid(cpu_target_valid), .cpu_target_code(cpu_target_code),
        .cpu_off_cmd(cpu_off_cmd), .cpu_state_valid(cpu_state_valid),
        .cpu_state_code(cpu_state_code));
    task automatic note(string what, logic [15:0] e, logic [15:0] s);
        checked++;
        if (e !== s) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : note
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic chk_reg(logic [7:0] a, logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        note($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
    endtask : chk_reg
    task automatic cpu(logic [1:0] k, logic [8:0] c);
        @(posedge clk_sys);
        go <= 1'b1;
        go_kind <= k;
        go_code <= c;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask : cpu
    // Bounded wait; waited keeps the ramp length for rate checks
    task automatic chk_vout(logic [8:0] e, int lim);
        waited = 0;
        @(negedge clk_sys);
        while (vout_code !== e && waited < lim) begin
            @(negedge clk_sys);
            waited++;
        end
        note("vout_code", {7'h00, e}, {7'h00, vout_code});
    endtask : chk_vout
    task automatic chk_state(logic [2:0] e);
        repeat (3) @(negedge clk_sys);
        note("power_state", {13'h0, e}, {13'h0, power_state});
    endtask : chk_state
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    initial begin
        #800_000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 14; i++) begin
            chk_reg(t_addr[i], t_rst[i]);
            wr(t_addr[i], 8'hff);
            chk_reg(t_addr[i], t_msk[i]);
            wr(t_addr[i], t_rst[i]);
        end
        wr(8'h8a, 8'h00);
        chk_reg(8'h8a, 8'h5a);
        chk_reg(8'h70, 8'h00);
        chk_reg(8'ha9, 8'h02);
        @(posedge clk_sys);
        system_power_code <= 10'h1ff;
        chk_reg(8'haa, 8'hc5);
        chk_reg(8'h87, 8'h01);
        chk_reg(8'h88, 8'h3a);
        wr(8'h80, 8'h00);
        chk_vout(9'd0, 3000);
        cpu(2'd2, 9'd3);
        chk_state(3'd3);
        cpu(2'd0, 9'd100);
        repeat (3) @(negedge clk_sys);
        note("ramp_busy", 16'h1, {15'h0, ramp_busy});
        chk_vout(9'd100, 400);
        wr(8'h80, 8'h04);
        chk_vout(9'd104, 100);
        note("offset ramp slow", 16'h1, {15'h0, waited >= 24});
        chk_state(3'd3);
        wr(8'h80, 8'hfe);
        cpu(2'd2, 9'd5);
        chk_vout(9'd98, 200);
        chk_state(3'd5);
        @(posedge clk_sys);
        cpu_up_slew <= 8'h01;
        wr(8'h80, 8'hff);
        chk_vout(9'd99, 400);
        note("offset ramp floor", 16'h1, {15'h0, waited <= 230});
        @(posedge clk_sys);
        cpu_up_slew <= 8'hff;
        cpu_offset_code <= 8'h02;
        wr(8'h80, 8'h05);
        cpu(2'd0, 9'h1fe);
        chk_vout(9'h1ff, 6000);
        @(posedge clk_sys);
        cpu_offset_code <= 8'hfe;
        wr(8'h80, 8'hf0);
        cpu(2'd0, 9'd5);
        chk_vout(9'd1, 6000);
        @(posedge clk_sys);
        cpu_offset_code <= 8'h00;
        wr(8'h80, 8'h03);
        cpu(2'd0, 9'd100);
        chk_vout(9'd103, 6000);
        wr(8'h82, 8'h10);
        wr(8'h83, 8'h01);
        wr(8'h81, 8'h01);
        chk_vout(9'h110, 3000);
        note("fixed entry slow", 16'h1, {15'h0, waited > 1000});
        cpu(2'd0, 9'd50);
        cpu(2'd2, 9'd6);
        repeat (100) @(posedge clk_sys);
        chk_vout(9'h110, 0);
        chk_state(3'd5);
        wr(8'h82, 8'h00);
        wr(8'h83, 8'h00);
        chk_vout(9'd0, 4000);
        wr(8'h81, 8'h00);
        chk_vout(9'd103, 4000);
        chk_state(3'd5);
        cpu(2'd1, 9'd0);
        chk_vout(9'd0, 1000);
        complete_run();
    end
endmodule : rcv_regs_bench
`default_nettype wire

/* File: tb/rcv_regs_monitor.sv */
/* Port checker for rcv_regs.
   Sees only top ports; follows fixed mode and the power snapshot itself. */
`timescale 1ns/1ps
`default_nettype none
module rcv_regs_monitor
    import rcv_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [9:0] system_power_code,
    input wire logic cpu_off_cmd,
    input wire logic [8:0] vout_code,
    input wire logic [2:0] power_state
);
    logic fix_ff;
    logic [7:0] snap_ff;
    wire logic nxt_fix = (reg_write && reg_addr == RCV_ADDR_FIX_EN) ? reg_wdata[0] : fix_ff;
    wire logic [1:0] pwr_top = system_power_code[9:8];
    wire logic [7:0] pwr_low = system_power_code[7:0];
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fix_ff <= 1'b0;
            snap_ff <= 8'h00;
        end else begin
            fix_ff <= nxt_fix;
            if (reg_read && reg_addr == RCV_ADDR_PWR_HI) begin
                snap_ff <= pwr_low;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence rd_s(logic [7:0] a);
        reg_read && reg_addr == a;
    endsequence
    sequence ofs_wr_s;
        reg_write && reg_addr == RCV_ADDR_OFFSET && !fix_ff;
    endsequence
    rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (reg_read && reg_addr < 8'h80 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    fix_en_bits_a: assert property (rd_s(8'h81) |=> reg_rdata == {7'h00, $past(fix_ff)})
        else $error("fixed enable read wrong");
    fix_hi_rsvd_a: assert property (rd_s(8'h83) |=> reg_rdata[7:1] == 7'h00)
        else $error("fixed high reserved bits set");
    pwr_high_a: assert property (rd_s(8'ha9) |=> reg_rdata == {6'h00, $past(pwr_top)})
        else $error("power high byte wrong");
    pwr_pair_a: assert property (rd_s(8'haa) |=> reg_rdata == $past(snap_ff))
        else $error("power low byte not the snapshot");
    ofs_full_a: assert property (ofs_wr_s |-> ##2 power_state == RCV_STATE_FULL)
        else $error("offset write did not force full state");
    off_zero_a: assert property (cpu_off_cmd && !fix_ff |-> ##[1:1000] vout_code == 9'h000)
        else $error("off command did not reach zero");
    fix_state_a: assert property (fix_ff && $past(fix_ff, 3) |-> $stable(power_state))
        else $error("power state moved in fixed mode");
    one_step_a: assert property ($changed(vout_code) && !(fix_ff && $past(fix_ff, 2)) |->
        (vout_code == $past(vout_code) + 9'h001 || vout_code == $past(vout_code) - 9'h001))
        else $error("output code jumped");
endmodule : rcv_regs_monitor
bind rcv_regs rcv_regs_monitor mon_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .system_power_code(system_power_code), .cpu_off_cmd(cpu_off_cmd),
    .vout_code(vout_code), .power_state(power_state)
);
`default_nettype wire
